// File: pts_device.sv
// device end: power-state sequencer driven by the toggle input
`timescale 1ns/100ps
module pts_device #(
    parameter int RTC_START_TK = pts_pkg::RTC_START_TK,  // rtc settle ticks
    parameter int SHUT_TK      = pts_pkg::SHUT_MIN_TK,   // minimum shutdown length in ticks
    parameter int ACQ_TK       = pts_pkg::ACQ_TK         // single-fix length
) (
    input  wire logic        clk_sys,            // 25 MHz clock
    input  wire logic        rst_n,              // power-on reset, active low
    pts_if.device            link,               // host side
    input  wire logic        strap_cts_pullup,   // cts strap present
    input  wire logic        strap_rts_pulldown, // rts strap present
    input  wire logic        strap_i2c,          // i2c strap
    input  wire logic        flow_ctrl_en,       // uart flow control used
    input  wire logic        req_low_power,      // enter duty-cycled mode
    input  wire logic        req_single_fix,     // enter single_fix_mode
    input  wire logic        work_done,          // pending work drained
    output logic             processor_run,      // internal processor running
    output logic             fix_strobe,         // position update pulse
    output logic             acq_active,         // single-fix acquisition running
    output logic [1:0]       host_if_sel,        // selected host interface
    output logic [2:0]       mode                // current power state
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]              div;       // clock-to-tick divider
        logic                     tick;      // one-cycle tick strobe
        logic                     pwr_ok;    // internal reset released
        logic                     straps;    // straps captured
        pts_pkg::pts_if_t         ifsel;     // host link choice
        pts_pkg::pts_mode_t       st;        // power state
        logic [pts_pkg::CNT_W-1:0] tcnt;     // state tick counter
        logic [pts_pkg::CNT_W-1:0] upd;      // update-rate counter
        logic [3:0]               hcnt;      // high dwell ticks
        logic [3:0]               lcnt;      // low dwell ticks
        logic                     armed;     // detector re-armed
        logic                     prev;      // last toggle sample
        logic                     seen_edge; // rising edge since arm
        logic                     awake;     // awake indicator
        logic                     run;       // processor running
        logic                     acq;       // acquisition active
        logic                     fix;       // update strobe
    } pts_dev_state_t;
    pts_dev_state_t s_reg;                   // registered state
    pts_dev_state_t s_next;                  // next state
    logic           pulse;                   // valid toggle detected
    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_next     = s_reg;
        pulse      = 1'b0;
        s_next.fix = 1'b0;
        s_next.pwr_ok = 1'b1;
        // tick generator
        s_next.tick = 1'b0;
        if (s_reg.div == 16'(pts_pkg::TICK_CYC - 1)) begin
            s_next.div  = 16'h0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.div = s_reg.div + 16'h0001;
        end
        // straps caught once after reset release
        if (s_reg.pwr_ok && !s_reg.straps) begin
            s_next.straps = 1'b1;
            if (strap_i2c) begin
                s_next.ifsel = pts_pkg::PTS_IF_I2C;
            end else if (strap_cts_pullup || strap_rts_pulldown) begin
                s_next.ifsel = pts_pkg::PTS_IF_UART;
            end else begin
                s_next.ifsel = pts_pkg::PTS_IF_SPI;
            end
        end
        // toggle detector, dwell in ticks
        s_next.prev = link.power_toggle;
        if (link.power_toggle && !s_reg.prev && s_reg.armed) begin
            s_next.seen_edge = 1'b1;
            s_next.hcnt      = 4'h0;
        end
        if (!link.power_toggle) begin
            s_next.hcnt = 4'h0;
            s_next.seen_edge = 1'b0;
            if (s_reg.tick && s_reg.lcnt != 4'(pts_pkg::DWELL_TICKS)) begin
                s_next.lcnt = s_reg.lcnt + 4'h1;
            end
            if (s_reg.lcnt == 4'(pts_pkg::DWELL_TICKS)) begin
                s_next.armed = 1'b1;
            end
        end else begin
            s_next.lcnt = 4'h0;
            if (s_reg.seen_edge && s_reg.tick) begin
                s_next.hcnt = s_reg.hcnt + 4'h1;
                if (s_reg.hcnt == 4'(pts_pkg::DWELL_TICKS - 1)) begin
                    pulse            = 1'b1;
                    s_next.armed     = 1'b0;
                    s_next.seen_edge = 1'b0;
                end
            end
        end
        // tick counter
        if (s_reg.tick) begin
            s_next.tcnt = s_reg.tcnt + 1'b1;
        end
        // default update rate while running
        if (s_reg.run && s_reg.tick) begin
            if (s_reg.upd == pts_pkg::CNT_W'(pts_pkg::UPDATE_TK - 1)) begin
                s_next.upd = '0;
                s_next.fix = 1'b1;
            end else begin
                s_next.upd = s_reg.upd + 1'b1;
            end
        end
        // power state machine
        unique case (s_reg.st)
            pts_pkg::PTS_BOOT: begin
                // hibernate while the rtc settles
                if (s_reg.tcnt == pts_pkg::CNT_W'(RTC_START_TK)) begin
                    s_next.st    = pts_pkg::PTS_STATE_A;
                    s_next.tcnt  = '0;
                    s_next.awake = 1'b1;
                end
            end
            pts_pkg::PTS_STATE_A: begin
                // ready pulse, then idle until toggled
                if (s_reg.awake && s_reg.tick &&
                    s_reg.tcnt == pts_pkg::CNT_W'(pts_pkg::AWAKE_PULSE_TK - 1)) begin
                    s_next.awake = 1'b0;
                end
                if (pulse) begin
                    s_next.st    = pts_pkg::PTS_WAKING;
                    s_next.tcnt  = '0;
                    s_next.awake = 1'b0;
                end
            end
            pts_pkg::PTS_HIBERNATE: begin
                if (pulse) begin
                    s_next.st   = pts_pkg::PTS_WAKING;
                    s_next.tcnt = '0;
                end
            end
            pts_pkg::PTS_WAKING: begin
                // awake rises a fixed number of ticks after the toggle
                if (s_reg.tcnt == pts_pkg::CNT_W'(pts_pkg::AWAKE_RISE_TK)) begin
                    s_next.st    = pts_pkg::PTS_FULL;
                    s_next.awake = 1'b1;
                    s_next.run   = 1'b1;
                    s_next.upd   = '0;
                end
            end
            pts_pkg::PTS_FULL: begin
                if (pulse || link.shutdown_cmd) begin
                    s_next.st   = pts_pkg::PTS_SHUTDOWN;
                    s_next.tcnt = '0;
                end else if (req_single_fix) begin
                    s_next.st = pts_pkg::PTS_SINGLE_FIX;
                end else if (req_low_power) begin
                    s_next.st = pts_pkg::PTS_LOW;
                end
            end
            pts_pkg::PTS_LOW: begin
                if (pulse) begin
                    s_next.st = pts_pkg::PTS_FULL;
                end else if (link.shutdown_cmd) begin
                    s_next.st   = pts_pkg::PTS_SHUTDOWN;
                    s_next.tcnt = '0;
                end
            end
            pts_pkg::PTS_SINGLE_FIX: begin
                if (pulse && !s_reg.acq) begin
                    s_next.acq  = 1'b1;
                    s_next.tcnt = '0;
                end else if (s_reg.acq && s_reg.tcnt == pts_pkg::CNT_W'(ACQ_TK)) begin
                    s_next.acq = 1'b0;
                end
                if (link.shutdown_cmd) begin
                    s_next.st   = pts_pkg::PTS_SHUTDOWN;
                    s_next.acq  = 1'b0;
                    s_next.tcnt = '0;
                end
            end
            pts_pkg::PTS_SHUTDOWN: begin
                // finish once past the minimum with work drained, or at the maximum
                if ((s_reg.tcnt >= pts_pkg::CNT_W'(SHUT_TK) && work_done) ||
                    s_reg.tcnt == pts_pkg::CNT_W'(pts_pkg::SHUT_MAX_TK)) begin
                    s_next.st    = pts_pkg::PTS_HIBERNATE;
                    s_next.awake = 1'b0;
                    s_next.run   = 1'b0;
                end
            end
        endcase
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{div: 16'h0000, tick: 1'b0, pwr_ok: 1'b0, straps: 1'b0,
                       ifsel: pts_pkg::PTS_IF_SPI, st: pts_pkg::PTS_BOOT, tcnt: '0,
                       upd: '0, hcnt: 4'h0, lcnt: 4'h0, armed: 1'b0, prev: 1'b1,
                       seen_edge: 1'b0, awake: 1'b0, run: 1'b0, acq: 1'b0, fix: 1'b0};
        end else if (!link.master_reset_n) begin
            s_reg <= '{div: 16'h0000, tick: 1'b0, pwr_ok: 1'b1, straps: 1'b0,
                       ifsel: pts_pkg::PTS_IF_SPI, st: pts_pkg::PTS_BOOT, tcnt: '0,
                       upd: '0, hcnt: 4'h0, lcnt: 4'h0, armed: 1'b0, prev: 1'b1,
                       seen_edge: 1'b0, awake: 1'b0, run: 1'b0, acq: 1'b0, fix: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.awake_indicator = s_reg.awake;
    // send gating per host link
    always_comb begin
        unique case (s_reg.ifsel)
            pts_pkg::PTS_IF_UART: link.tx_enable = s_reg.run &&
                                      (!flow_ctrl_en || !link.cts_n);
            pts_pkg::PTS_IF_I2C:  link.tx_enable = s_reg.run && link.i2c_grant;
            default:              link.tx_enable = s_reg.run;
        endcase
    end
    assign processor_run = s_reg.run;
    assign fix_strobe    = s_reg.fix;
    assign acq_active    = s_reg.acq;
    assign host_if_sel   = s_reg.ifsel;
    assign mode          = s_reg.st;
endmodule : pts_device

// File: pts_host.sv
// host end: drives toggle pulses and waits on the awake indicator
`timescale 1ns/100ps
module pts_host #(
    parameter int RETRY_TK = pts_pkg::RETRY_TK,   // retry period in ticks
    parameter int SPI_TK   = pts_pkg::RETRY_TK    // awake to spi start
) (
    input  wire logic clk_sys,       // 25 MHz clock
    input  wire logic rst_n,         // reset, active low
    pts_if.host       link,          // device side
    input  wire logic start_req,     // user asks device on
    input  wire logic stop_req,      // user asks device off
    input  wire logic cmd_shutdown,  // send shutdown command
    input  wire logic user_cts_n,    // host clear-to-send level
    input  wire logic user_grant,    // i2c arbitration result
    output logic      spi_go,        // spi traffic may start
    output logic      supply_en,     // main supply switch
    output logic      busy           // pulse in progress
);
    typedef enum logic [1:0] {H_IDLE, H_HIGH, H_LOW} pts_hst_t;
    typedef struct packed {
        pts_hst_t                  st;    // pulse phase
        logic [pts_pkg::CNT_W-1:0] cnt;   // tick counter
        logic [15:0]               div;   // tick divider
        logic                      want;  // start pending, retrying
        logic [pts_pkg::CNT_W-1:0] rty;   // retry counter
        logic [pts_pkg::CNT_W-1:0] spc;   // spi wait counter
        logic                      go;    // spi allowed
    } pts_host_state_t;
    pts_host_state_t h_reg;               // registered state
    pts_host_state_t h_next;              // next state
    logic            tick;                // tick strobe
    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        h_next = h_reg;
        tick   = (h_reg.div == 16'(pts_pkg::TICK_CYC - 1));
        h_next.div = tick ? 16'h0000 : h_reg.div + 16'h0001;
        if (start_req) begin
            h_next.want = 1'b1;
        end
        if (link.awake_indicator) begin
            h_next.want = 1'b0;
        end
        // pulse with one extra tick of dwell margin
        unique case (h_reg.st)
            H_IDLE: begin
                if ((stop_req && link.awake_indicator) ||
                    (h_reg.want && h_reg.rty == '0)) begin
                    h_next.st  = H_HIGH;
                    h_next.cnt = '0;
                end
            end
            H_HIGH: begin
                if (tick) begin
                    h_next.cnt = h_reg.cnt + 1'b1;
                end
                if (h_reg.cnt == pts_pkg::CNT_W'(pts_pkg::DWELL_TICKS + 1)) begin
                    h_next.st  = H_LOW;
                    h_next.cnt = '0;
                end
            end
            H_LOW: begin
                if (tick) begin
                    h_next.cnt = h_reg.cnt + 1'b1;
                end
                if (h_reg.cnt == pts_pkg::CNT_W'(pts_pkg::DWELL_TICKS + 1)) begin
                    h_next.st = H_IDLE;
                end
            end
            default: h_next.st = H_IDLE;
        endcase
        // repeat once per second until awake
        if (h_reg.want && tick) begin
            h_next.rty = (h_reg.rty == pts_pkg::CNT_W'(RETRY_TK - 1)) ? '0
                         : h_reg.rty + 1'b1;
        end
        if (!h_reg.want) begin
            h_next.rty = '0;
        end
        // spi start one second after awake
        if (!link.awake_indicator) begin
            h_next.spc = '0;
            h_next.go  = 1'b0;
        end else if (tick && !h_reg.go) begin
            h_next.spc = h_reg.spc + 1'b1;
            if (h_reg.spc == pts_pkg::CNT_W'(SPI_TK - 1)) begin
                h_next.go = 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            h_reg <= '{st: H_IDLE, cnt: '0, div: 16'h0000, want: 1'b0, rty: '0,
                       spc: '0, go: 1'b0};
        end else begin
            h_reg <= h_next;
        end
    end
    assign link.power_toggle   = (h_reg.st == H_HIGH);
    assign link.master_reset_n = 1'b1;
    assign link.cts_n          = user_cts_n;
    assign link.i2c_grant      = user_grant;
    assign link.shutdown_cmd   = cmd_shutdown;
    assign supply_en           = link.awake_indicator;
    assign spi_go              = h_reg.go;
    assign busy                = (h_reg.st != H_IDLE);
endmodule : pts_host

// File: pts_if.sv
// link between host and power toggle sequencer
`timescale 1ns/100ps
interface pts_if;
    logic power_toggle;                 // host toggle pulse
    logic awake_indicator;              // device awake level
    logic master_reset_n;               // optional host reset, active low
    logic cts_n;                        // host clear-to-send, active low
    logic i2c_grant;                    // i2c arbitration won
    logic shutdown_cmd;                 // decoded shutdown command strobe
    logic tx_enable;                    // device may send on its link
    modport device (input power_toggle, master_reset_n, cts_n, i2c_grant, shutdown_cmd,
                    output awake_indicator, tx_enable);
    modport host   (output power_toggle, master_reset_n, cts_n, i2c_grant, shutdown_cmd,
                    input awake_indicator, tx_enable);
endinterface : pts_if

// File: pts_link_props.sv
// concurrent checks on the host-device link
`timescale 1ns/100ps
module pts_link_props #(
    parameter int SHUT_TK = pts_pkg::SHUT_MIN_TK // shutdown ticks
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_toggle,
    input wire logic awake_indicator,
    input wire logic master_reset_n,
    input wire logic shutdown_cmd,
    input wire logic tx_enable
);
    localparam int T = pts_pkg::TICK_CYC;         // cycles per tick
    localparam int D = pts_pkg::DWELL_TICKS * T;  // dwell in cycles
    int hi_reg, lo_reg, aw_reg, tg_reg, sh_reg;   // run lengths in cycles
    // toggle high run, low run, awake run
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) hi_reg <= 0;
        else hi_reg <= power_toggle ? hi_reg + 1 : 0;
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) lo_reg <= 0;
        else lo_reg <= power_toggle ? 0 : lo_reg + 1;
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) aw_reg <= 0;
        else aw_reg <= awake_indicator ? aw_reg + 1 : 0;
    // cycles since last toggle rise, large before any
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) tg_reg <= 1000000;
        else tg_reg <= (power_toggle && hi_reg == 0) ? 0 : tg_reg + 1;
    // cycles awake since a shutdown command
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) sh_reg <= 0;
        else sh_reg <= !awake_indicator ? 0 : (shutdown_cmd || sh_reg > 0) ? sh_reg + 1 : 0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_HOST_NO_RESET: assert property (master_reset_n)
        else $error("host drove master reset");
    AST_TOGGLE_HIGH: assert property ($fell(power_toggle) |-> hi_reg >= D)
        else $error("toggle high too short");
    AST_TOGGLE_LOW: assert property ($rose(power_toggle) |-> lo_reg >= D)
        else $error("toggle low too short");
    AST_AWAKE_WIDTH: assert property ($fell(awake_indicator) |-> aw_reg >= 9 * T)
        else $error("awake pulse too short");
    AST_AWAKE_HOLD: assert property ($rose(awake_indicator) |-> awake_indicator [*8])
        else $error("awake glitch");
    AST_RISE_DELAY: assert property ($rose(awake_indicator) |->
        tg_reg > 100 * T || (tg_reg >= 6 * T && tg_reg <= 13 * T))
        else $error("awake rise delay wrong");
    AST_TX_GATED: assert property (!awake_indicator |-> !tx_enable)
        else $error("send enabled while asleep");
    AST_SHUT_MAX: assert property (sh_reg <= (pts_pkg::SHUT_MAX_TK + 1) * T)
        else $error("shutdown too long");
    AST_SHUT_MIN: assert property ($fell(awake_indicator) && sh_reg > 0 |->
        sh_reg >= (SHUT_TK - 1) * T)
        else $error("shutdown too short");
    COV_START: cover property ($rose(awake_indicator) && tg_reg < 20 * T);
    COV_CMD_OFF: cover property ($fell(awake_indicator) && sh_reg > 0);
    COV_PULSE: cover property ($fell(power_toggle));
endmodule : pts_link_props

// File: pts_pkg.sv
// shared constants and types of the power toggle sequencer
// Overview of operation
// - power-up enters hibernate, then reaches state_a
// - internal power-on reset, host reset optional
// - state_a waits for valid toggle pulse
// - ten-tick awake pulse marks state_a reached
// - host may retry toggle once per second
// - pulse needs high and low dwell
// - toggle in hibernate goes full power
// - toggle in low power goes full power
// - toggle in single-fix starts one cycle
// - toggle in full power starts shutdown
// - awake rises six ticks after toggle
// - main supply ready within 1 ms
// - awake high means processor running, except during the state_a ready pulse
// - uart without flow control starts 4800 bps
// - flow control waits for host clear-to-send
// - i2c sends spontaneously without contention
// - i2c defers until arbitration grants bus
// - host starts spi one second after awake
// - shutdown commands also enter hibernate
// - shutdown lasts 10 ms to 900 ms
// - spi default without pull straps
// - default update rate once per second
package pts_pkg;
    // ------------------------------------------------------------
    // clock and tick
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25000000;             // system clock rate
    localparam int RTC_HZ          = 32768;                // tick rate
    localparam int TICK_CYC        = CLK_HZ / RTC_HZ;      // cycles per tick, rounded down
    // ------------------------------------------------------------
    // timing in ticks
    // ------------------------------------------------------------
    localparam int DWELL_US        = 100;                  // toggle high/low dwell
    localparam int DWELL_TICKS     = (DWELL_US * RTC_HZ + 999999) / 1000000; // rounded up
    localparam int AWAKE_PULSE_TK  = 10;                   // ready pulse width
    localparam int AWAKE_RISE_TK   = 6;                    // toggle to awake high
    localparam int RTC_START_TK    = 16;                   // rtc settle, shortened default
    localparam int ACQ_TK          = 64;                   // single-fix cycle length
    localparam int SHUT_MIN_MS     = 10;                   // shortest shutdown
    localparam int SHUT_MAX_MS     = 900;                  // longest shutdown
    localparam int SHUT_MIN_TK     = (SHUT_MIN_MS * RTC_HZ + 999) / 1000;
    localparam int SHUT_MAX_TK     = (SHUT_MAX_MS * RTC_HZ) / 1000;
    localparam int SUPPLY_MS       = 1;                    // main supply ready time
    localparam int SUPPLY_TK       = (SUPPLY_MS * RTC_HZ) / 1000;
    localparam int RETRY_TK        = RTC_HZ;               // one second in ticks
    localparam int UPDATE_TK       = RTC_HZ;               // default update period
    localparam int UART_BAUD       = 4800;                 // default uart rate
    localparam int CNT_W           = 20;                   // tick counter width
    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PTS_IF_SPI, PTS_IF_UART, PTS_IF_I2C} pts_if_t; // host link
    typedef enum logic [2:0] {
        PTS_BOOT, PTS_STATE_A, PTS_HIBERNATE, PTS_WAKING, PTS_FULL, PTS_LOW,
        PTS_SINGLE_FIX, PTS_SHUTDOWN
    } pts_mode_t;                                          // power states
endpackage : pts_pkg

// File: tb_power_toggle_sequencer.sv
// self-checking bench: host and device joined by the link
`timescale 1ns/100ps
module tb_power_toggle_sequencer;
    localparam int T = pts_pkg::TICK_CYC;  // cycles per tick
    logic clk_sys, rst_n, start_req, stop_req, cmd_shutdown, user_cts_n, user_grant;
    logic work_done, flow_ctrl_en, run, fix, acq, spi_go, supply_en, busy;
    logic req_lp, req_sf, strap_i2c;       // mode requests, i2c strap
    logic [1:0] host_if_sel;               // chosen host link
    logic [2:0] mode;                      // power state
    int         fail_count, n_tests, cyc;  // counters
    pts_if link ();
    pts_device #(.RTC_START_TK(4), .SHUT_TK(4), .ACQ_TK(8)) pts_device_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .strap_cts_pullup(1'b0),
        .strap_rts_pulldown(1'b0), .strap_i2c(strap_i2c), .flow_ctrl_en(flow_ctrl_en),
        .req_low_power(req_lp), .req_single_fix(req_sf), .work_done(work_done),
        .processor_run(run), .fix_strobe(fix), .acq_active(acq),
        .host_if_sel(host_if_sel), .mode(mode));
    pts_host #(.RETRY_TK(50), .SPI_TK(8)) pts_host_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .link(link), .start_req(start_req),
        .stop_req(stop_req), .cmd_shutdown(cmd_shutdown), .user_cts_n(user_cts_n),
        .user_grant(user_grant), .spi_go(spi_go), .supply_en(supply_en), .busy(busy));
    pts_link_props #(.SHUT_TK(4)) pts_link_props_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .power_toggle(link.power_toggle),
        .awake_indicator(link.awake_indicator), .master_reset_n(link.master_reset_n),
        .shutdown_cmd(link.shutdown_cmd), .tx_enable(link.tx_enable));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // user request: 0 start, 1 stop, 2 shutdown command
    task automatic ask(input int k);
        @(posedge clk_sys iff busy === 1'b0);
        start_req <= (k == 0);
        stop_req <= (k == 1);
        cmd_shutdown <= (k == 2);
        @(posedge clk_sys iff (busy === 1'b1 || k == 2));
        {start_req, stop_req, cmd_shutdown} <= 3'h0;
    endtask : ask
    // wait for awake level, then settle
    task automatic aw(input logic v);
        @(posedge clk_sys iff link.awake_indicator === v);
        @(negedge clk_sys);
    endtask : aw
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // cycle ceiling against hangs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 95000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        {rst_n, start_req, stop_req, cmd_shutdown, user_cts_n, req_lp, req_sf, strap_i2c} = 8'h00;
        {user_grant, work_done, flow_ctrl_en} = 3'h6;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        aw(1'b1);
        aw(1'b0);
        chk("mode", pts_pkg::PTS_STATE_A, mode);
        chk("run", 3'h0, 3'(run));
        $display("test ready done");
        ask(0);
        aw(1'b1);
        chk("mode", pts_pkg::PTS_FULL, mode);
        chk("run", 3'h1, 3'(run));
        chk("if", 3'h0, 3'(host_if_sel));
        chk("supply", 3'h1, 3'(supply_en));
        chk("spi early", 3'h0, 3'(spi_go));
        repeat (10 * T) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("spi", 3'h1, 3'(spi_go));
        $display("test start done");
        ask(1);
        aw(1'b0);
        chk("mode", pts_pkg::PTS_HIBERNATE, mode);
        ask(0);
        aw(1'b1);
        chk("mode", pts_pkg::PTS_FULL, mode);
        @(posedge clk_sys);
        req_lp <= 1'b1;
        @(posedge clk_sys);
        req_lp <= 1'b0;
        @(negedge clk_sys);
        chk("mode", pts_pkg::PTS_LOW, mode);
        ask(1);
        repeat (5 * T) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("mode", pts_pkg::PTS_FULL, mode);
        @(posedge clk_sys);
        req_sf <= 1'b1;
        @(posedge clk_sys);
        req_sf <= 1'b0;
        ask(1);
        repeat (5 * T) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("mode", pts_pkg::PTS_SINGLE_FIX, mode);
        chk("acq", 3'h1, 3'(acq));
        repeat (10 * T) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("acq", 3'h0, 3'(acq));
        $display("test modes done");
        ask(2);
        aw(1'b0);
        chk("mode", pts_pkg::PTS_HIBERNATE, mode);
        $display("test shutdown done");
        @(posedge clk_sys);
        {rst_n, strap_i2c, user_grant} <= 3'h2;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        aw(1'b1);
        chk("if", 3'h2, 3'(host_if_sel));
        aw(1'b0);
        ask(0);
        aw(1'b1);
        chk("tx", 3'h0, 3'(link.tx_enable));
        @(posedge clk_sys);
        user_grant <= 1'b1;
        @(negedge clk_sys);
        chk("tx", 3'h1, 3'(link.tx_enable));
        chk("fix", 3'h0, 3'(fix));
        $display("test i2c done");
        give_verdict();
    end
endmodule : tb_power_toggle_sequencer
